/* File: hw/aie_pkg.sv */
// Purpose: Shared constants for the add instruction execute block
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   Opcode fields, flag positions and addressing constants
package aie_pkg;
    localparam int          AIE_DW          = 8;            // Data width
    localparam int          AIE_AW          = 12;           // Data memory address width
    localparam logic [7:0]  AIE_OP_LIT      = 8'h0F;        // Literal add upper byte
    localparam logic [5:0]  AIE_OP_REG      = 6'h09;        // Register add upper six bits
    localparam int          AIE_D_BIT       = 9;            // Destination select position
    localparam int          AIE_A_BIT       = 8;            // Bank addressing position
    localparam logic [7:0]  AIE_IDX_LIMIT   = 8'h5F;        // Highest indexed offset
    localparam logic [7:0]  AIE_ACC_SPLIT   = 8'h60;        // Access bank low/high split
    localparam logic [3:0]  AIE_ACC_HI_BANK = 4'hF;         // Bank of upper access half
    localparam logic [3:0]  AIE_ACC_LO_BANK = 4'h0;         // Bank of lower access half
    localparam logic [7:0]  AIE_W_RST       = 8'h00;        // Accumulator reset value
    localparam logic [4:0]  AIE_FLG_RST     = 5'h00;        // Flags reset value
    localparam int          AIE_F_C         = 0;            // Carry flag position
    localparam int          AIE_F_DC        = 1;            // Digit carry flag position
    localparam int          AIE_F_Z         = 2;            // Zero flag position
    localparam int          AIE_F_OV        = 3;            // Overflow flag position
    localparam int          AIE_F_N         = 4;            // Negative flag position

    // Addressing mode of a register operand
    typedef enum logic [1:0] {AIE_AM_ACCESS, AIE_AM_BANKED, AIE_AM_INDEXED} aie_amode_t;
endpackage : aie_pkg

/* File: hw/aie_alu_if.sv */
// Purpose: Carrier between decoder and adder
// Assumes: Single clock, combinational adder
// Notes:   Operands in, sum and flags out
`timescale 1ns/1ps
interface aie_alu_if;
    logic [7:0] op_a;    // Accumulator operand
    logic [7:0] op_b;    // Literal or register operand
    logic [7:0] sum;     // Result
    logic [4:0] flags;   // Result flags

    // Decoder side
    modport ctl (output op_a, output op_b, input sum, input flags);
    // Adder side
    modport alu (input op_a, input op_b, output sum, output flags);
endinterface : aie_alu_if

/* File: hw/aie_adder.sv */
// Purpose: Eight-bit adder with status flags
// Assumes: Purely combinational
// Notes:   Flag order follows the package positions
`timescale 1ns/1ps
module aie_adder (
    aie_alu_if.alu a
);
    logic [8:0] full;    // Sum with carry out
    logic [4:0] lo;      // Low nibble sum

    // Sum and flag generation
    always_comb begin
        full = {1'b0, a.op_a} + {1'b0, a.op_b};
        lo   = {1'b0, a.op_a[3:0]} + {1'b0, a.op_b[3:0]};
        a.sum = full[7:0];
        a.flags = '0;
        a.flags[aie_pkg::AIE_F_C]  = full[8];
        a.flags[aie_pkg::AIE_F_DC] = lo[4];
        a.flags[aie_pkg::AIE_F_Z]  = (full[7:0] == 8'h00);
        // Overflow: equal signs in, different sign out
        a.flags[aie_pkg::AIE_F_OV] = (a.op_a[7] == a.op_b[7]) && (full[7] != a.op_a[7]);
        a.flags[aie_pkg::AIE_F_N]  = full[7];
    end
endmodule : aie_adder

/* File: hw/aie_core.sv */
// Purpose: Execute the literal add and register add instructions
// Assumes: Data memory read is combinational within the cycle
// Notes:   One instruction per clock when instr_valid is high
//          A register written by one word is forwarded to the next
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module aie_core (
    input  wire logic        mclk,          // Instruction clock
    input  wire logic        rstn,          // Async reset, active low
    input  wire logic        instr_valid,   // Instruction word present
    input  wire logic [15:0] instr,         // Instruction word
    input  wire logic        ext_set_en,    // Extended instruction set enabled
    input  wire logic [3:0]  bank_select_register, // Current bank
    input  wire logic [11:0] index_base,    // Index pointer for indexed mode
    input  wire logic [7:0]  mem_rdata,     // Data read at mem_addr
    output logic [11:0]      mem_addr,      // Data memory address (comb read)
    output logic [11:0]      wr_addr_q,     // Registered write address
    output logic [7:0]       wr_data_q,     // Registered write data
    output logic             wr_en_q,       // Registered write pulse
    output logic [7:0]       acc_q,         // Working accumulator
    output logic [4:0]       flags_q,       // N OV Z DC C
    output logic             done_q         // Add executed last cycle
);
    aie_alu_if alu_b ();                    // Adder carrier
    aie_pkg::aie_amode_t amode;             // Current addressing mode
    logic is_lit;                           // Literal add decoded
    logic is_reg;                           // Register add decoded
    logic [7:0] f;                          // Register offset field

    aie_adder u_add (.a(alu_b));

    // Decode opcode classes
    // Only the two add opcodes are recognised; every other word leaves
    // the accumulator, flags and memory untouched
    function automatic logic dec_lit(input logic [15:0] w);
        return w[15:8] == aie_pkg::AIE_OP_LIT;
    endfunction : dec_lit
    function automatic logic dec_reg(input logic [15:0] w);
        return w[15:10] == aie_pkg::AIE_OP_REG;
    endfunction : dec_reg

    assign is_lit = instr_valid && dec_lit(instr);
    assign is_reg = instr_valid && dec_reg(instr);
    assign f      = instr[7:0];

    // Addressing mode select
    // The bank bit wins over the extended set; indexed mode only covers
    // the low offsets, the rest of the access bank stays as it is
    always_comb begin
        if (instr[aie_pkg::AIE_A_BIT]) begin
            amode = aie_pkg::AIE_AM_BANKED;
        end else if (ext_set_en && f <= aie_pkg::AIE_IDX_LIMIT) begin
            amode = aie_pkg::AIE_AM_INDEXED;
        end else begin
            amode = aie_pkg::AIE_AM_ACCESS;
        end
    end

    // Address resolution per mode
    // Indexed offsets wrap within the twelve-bit address space
    always_comb begin
        unique case (amode)
            aie_pkg::AIE_AM_BANKED:  mem_addr = {bank_select_register, f};
            aie_pkg::AIE_AM_INDEXED: mem_addr = index_base + {4'h0, f};
            aie_pkg::AIE_AM_ACCESS:  begin
                // Access bank ignores bank select
                // Low offsets sit in bank zero, high offsets in the top bank
                mem_addr = (f < aie_pkg::AIE_ACC_SPLIT) ? {aie_pkg::AIE_ACC_LO_BANK, f}
                                                        : {aie_pkg::AIE_ACC_HI_BANK, f};
            end
            default: mem_addr = {bank_select_register, f};
        endcase
    end

    // Register operand as the instruction stream sees it. The store of a
    // register add lands in memory one edge after wr_en_q, so the word that
    // follows it would read the old value; the pending write is folded in.
    logic       fwd_hit;                    // Pending write hits this read
    logic [7:0] reg_operand;                // Register value for this word

    assign fwd_hit     = wr_en_q && (wr_addr_q == mem_addr);
    assign reg_operand = fwd_hit ? wr_data_q : mem_rdata;

    // Adder operands
    assign alu_b.op_a = acc_q;
    assign alu_b.op_b = is_lit ? f : reg_operand;

    // Accumulator update
    // A register add with destination one leaves the accumulator alone
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= aie_pkg::AIE_W_RST;
        end else if (is_lit) begin
            acc_q <= alu_b.sum;
        end else if (is_reg && !instr[aie_pkg::AIE_D_BIT]) begin
            acc_q <= alu_b.sum;
        end
    end

    // Flags update for both adds
    // Flags follow every add, whatever its destination
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= aie_pkg::AIE_FLG_RST;
        end else if (is_lit || is_reg) begin
            flags_q <= alu_b.flags;
        end
    end

    // Register write back
    // Address and data are captured on every register add; the write pulse
    // only rises for destination one, so memory is untouched otherwise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_en_q   <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else begin
            wr_en_q <= is_reg && instr[aie_pkg::AIE_D_BIT];
            if (is_reg) begin
                wr_addr_q <= mem_addr;
                wr_data_q <= alu_b.sum;
            end
        end
    end

    // Completion pulse
    // One pulse per executed add, none for ignored words
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= is_lit || is_reg;
        end
    end

    // Operands of the word taken at the last edge, kept for the checks
    // below so that expected results do not reuse the adder's outputs
    logic [7:0] chk_acc_p;                  // Accumulator before the add
    logic [7:0] chk_mem_p;                  // Register value before the add
    logic [7:0] chk_f_p;                    // Offset or literal field
    logic       chk_lit_p;                  // Last word was a literal add
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chk_acc_p <= '0;
            chk_mem_p <= '0;
            chk_f_p   <= '0;
            chk_lit_p <= 1'b0;
        end else begin
            chk_acc_p <= acc_q;
            chk_mem_p <= reg_operand;
            chk_f_p   <= f;
            chk_lit_p <= is_lit;
        end
    end

    // Reference sums of the last taken word, built from the saved operands
    logic [7:0] chk_opb_p;                  // Second operand of the last word
    logic [8:0] chk_sum9;                   // Sum with carry out
    logic [4:0] chk_nib;                    // Low nibble sum with carry
    assign chk_opb_p = chk_lit_p ? chk_f_p : chk_mem_p;
    assign chk_sum9  = {1'b0, chk_acc_p} + {1'b0, chk_opb_p};
    assign chk_nib   = {1'b0, chk_acc_p[3:0]} + {1'b0, chk_opb_p[3:0]};

    // Checks on executed and ignored words, all on mclk and held off during reset
    chk_reg_sum: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg |=> done_q && (wr_en_q ? wr_data_q : acc_q) == 8'(chk_acc_p + chk_mem_p))
        else $error("register add sum wrong");
    chk_dest_acc: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg && !instr[aie_pkg::AIE_D_BIT] |=> !wr_en_q)
        else $error("accumulator destination wrote memory");
    chk_dest_reg: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg && instr[aie_pkg::AIE_D_BIT] |=> wr_en_q && $stable(acc_q))
        else $error("register destination failed");
    chk_access_bank: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg && !instr[aie_pkg::AIE_A_BIT] && !ext_set_en |-> mem_addr[7:0] == f
            && (mem_addr[11:8] == aie_pkg::AIE_ACC_LO_BANK || mem_addr[11:8] == aie_pkg::AIE_ACC_HI_BANK))
        else $error("access bank address wrong");
    chk_banked: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg && instr[aie_pkg::AIE_A_BIT] |-> mem_addr == {bank_select_register, f})
        else $error("banked address wrong");
    chk_indexed: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg && !instr[aie_pkg::AIE_A_BIT] && ext_set_en && f <= aie_pkg::AIE_IDX_LIMIT
            |-> mem_addr == 12'(index_base + f))
        else $error("indexed address wrong");
    chk_lit_add: assert property (@(posedge mclk) disable iff (!rstn)
        is_lit |=> acc_q == 8'(chk_acc_p + $past(f)) && !wr_en_q)
        else $error("literal add wrong");
    chk_zero_flag: assert property (@(posedge mclk) disable iff (!rstn)
        (is_lit || is_reg) |=> flags_q[aie_pkg::AIE_F_Z] == (chk_sum9[7:0] == 8'h00))
        else $error("zero flag wrong");
    chk_carry_flags: assert property (@(posedge mclk) disable iff (!rstn)
        (is_lit || is_reg) |=> flags_q[aie_pkg::AIE_F_C] == chk_sum9[8]
            && flags_q[aie_pkg::AIE_F_DC] == chk_nib[4])
        else $error("carry flags wrong");
    chk_sign_flags: assert property (@(posedge mclk) disable iff (!rstn)
        (is_lit || is_reg) |=> flags_q[aie_pkg::AIE_F_N] == chk_sum9[7]
            && flags_q[aie_pkg::AIE_F_OV] == (chk_acc_p[7] == chk_opb_p[7] && chk_sum9[7] != chk_acc_p[7]))
        else $error("sign or overflow flag wrong");
    chk_write_target: assert property (@(posedge mclk) disable iff (!rstn)
        is_reg && instr[aie_pkg::AIE_D_BIT] |=> wr_addr_q == $past(mem_addr))
        else $error("write back address wrong");
    chk_idle_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        !(is_lit || is_reg) |=> !done_q && !wr_en_q && $stable(acc_q) && $stable(flags_q))
        else $error("state moved without an add");

    // Main scenarios: each add kind, both destinations, indexed and forwarded reads

    cov_lit: cover property (@(posedge mclk) disable iff (!rstn) is_lit);
    cov_reg_w: cover property (@(posedge mclk) disable iff (!rstn) is_reg && !instr[aie_pkg::AIE_D_BIT]);
    cov_reg_f: cover property (@(posedge mclk) disable iff (!rstn) is_reg && instr[aie_pkg::AIE_D_BIT]);
    cov_idx: cover property (@(posedge mclk) disable iff (!rstn) is_reg && amode == aie_pkg::AIE_AM_INDEXED);
    cov_fwd: cover property (@(posedge mclk) disable iff (!rstn) is_reg && fwd_hit);
endmodule : aie_core

/* File: sim/aie_dmem_model.sv */
// Purpose: Data memory model facing the add execute block
// Assumes: Read is combinational, write lands on the edge after the write pulse
// Notes:   Preloaded with an address-derived pattern that repeats every 256 locations
`timescale 1ns/1ps
module aie_dmem_model (
    input  wire logic        mclk,       // Instruction clock
    input  wire logic [11:0] mem_addr,   // Read address
    input  wire logic [11:0] wr_addr_q,  // Write address
    input  wire logic [7:0]  wr_data_q,  // Write data
    input  wire logic        wr_en_q,    // Write pulse
    output logic      [7:0]  mem_rdata   // Read data
);
    logic [7:0] mem [4096];  // Storage cells

    // Preload pattern
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i * 7 + 3);
        end
    end

    // Same-cycle read
    assign mem_rdata = mem[mem_addr];

    // Store on the write pulse
    always @(posedge mclk) begin
        if (wr_en_q) begin
            mem[wr_addr_q] <= wr_data_q;
        end
    end
endmodule : aie_dmem_model

/* File: sim/add_instruction_execute_tb_top.sv */
// Purpose: Self-checking bench for the add execute core
// Assumes: One instruction per cycle, results visible just after the taking edge
// Notes:   Expected values come from a reference model kept in this bench
`timescale 1ns/1ps
module add_instruction_execute_tb_top;
    logic        mclk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0, wr_en_q, done_q;
    logic [15:0] instr = 16'h0000;       // Instruction word
    logic [3:0]  bank_select_register = 4'h0;
    logic [11:0] index_base = 12'h000, mem_addr, wr_addr_q;
    logic [7:0]  mem_rdata, wr_data_q, acc_q, exp_acc = 8'h00;
    logic [4:0]  flags_q, exp_flg = 5'h00;
    int          failures = 0, n_checks = 0;

    always #20 mclk = ~mclk;  // 25 MHz

    aie_core aie_core_i (.mclk(mclk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .ext_set_en(ext_set_en), .bank_select_register(bank_select_register), .index_base(index_base),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
        .wr_en_q(wr_en_q), .acc_q(acc_q), .flags_q(flags_q), .done_q(done_q));
    aie_dmem_model aie_dmem_model_i (.mclk(mclk), .mem_addr(mem_addr), .wr_addr_q(wr_addr_q),
        .wr_data_q(wr_data_q), .wr_en_q(wr_en_q), .mem_rdata(mem_rdata));

    // Compare one result
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Expected results of the word taken at the last edge
    logic        pend_v  = 1'b0;         // An add was taken
    logic        pend_we = 1'b0;         // It writes memory
    logic [11:0] pend_ad = 12'h000;      // Its register address
    logic [7:0]  pend_s  = 8'h00;        // Its sum

    // Drive one word at a rising edge, check the word taken at that edge,
    // then work out what this word must produce
    task op(input logic [15:0] w, input logic v);
        logic [11:0] ad;
        logic [7:0]  b, s;
        logic [8:0]  t;
        logic        is_l, is_r, we;
        instr <= w;
        instr_valid <= v;
        #1;
        chk(12'(done_q), 12'(pend_v));
        chk(12'(acc_q), 12'(exp_acc));
        chk(12'(flags_q), 12'(exp_flg));
        chk(12'(wr_en_q), 12'(pend_we));
        if (pend_we) begin
            chk(wr_addr_q, pend_ad);
            chk(12'(wr_data_q), 12'(pend_s));
        end
        is_l = v && w[15:8] == 8'h0F;
        is_r = v && w[15:10] == 6'h09;
        if (w[8]) ad = {bank_select_register, w[7:0]};                 // Banked
        else if (ext_set_en && w[7:0] <= 8'h5F) ad = index_base + 12'(w[7:0]);  // Indexed
        else ad = {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};           // Access bank halves
        // A register written by the word before has not reached memory yet
        if (is_l) b = w[7:0];
        else if (pend_we && pend_ad == ad) b = pend_s;
        else b = aie_dmem_model_i.mem[ad];
        t = {1'b0, exp_acc} + {1'b0, b};
        s = t[7:0];
        we = is_r && w[9];
        if (is_r) chk(mem_addr, ad);
        if (is_l || is_r) begin
            exp_flg = {s[7], exp_acc[7] == b[7] && s[7] != b[7], s == 8'h00,
                       5'(exp_acc[3:0]) + 5'(b[3:0]) > 5'd15, t[8]};
            if (!we) exp_acc = s;
        end
        pend_v  = is_l || is_r;
        pend_we = we;
        pend_ad = ad;
        pend_s  = s;
        @(posedge mclk);
    endtask : op

    // Counts, verdict and end of run
    task complete_run;
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Hang guard
    initial begin
        #200000;
        failures++;
        complete_run();
    end

    // Main sequence, all instructions back to back
    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        chk(12'(acc_q), 12'h000);
        chk(12'(flags_q), 12'h000);
        chk(12'(done_q), 12'h000);
        chk(12'(wr_en_q), 12'h000);
        @(posedge mclk);
        op(16'h0F10, 1'b1);
        op(16'h0F15, 1'b1);
        op(16'h0F5B, 1'b1);
        op(16'h0F80, 1'b1);
        op(16'h0F88, 1'b1);
        op(16'h0FFF, 1'b1);
        $display("literal add test done");
        op(16'h2420, 1'b1);
        op(16'h2680, 1'b1);
        op(16'h2480, 1'b1);
        bank_select_register <= 4'h5;
        op(16'h2733, 1'b1);
        op(16'h2533, 1'b1);
        $display("register add test done");
        ext_set_en <= 1'b1;
        index_base <= 12'hFF0;
        op(16'h2620, 1'b1);
        op(16'h245F, 1'b1);
        op(16'h2460, 1'b1);
        op(16'h2570, 1'b1);
        $display("indexed mode test done");
        op(16'h0B12, 1'b1);
        op(16'h0F33, 1'b0);
        op(16'h2420, 1'b0);
        op(16'h0000, 1'b0);
        $display("ignored word test done");
        complete_run();
    end
endmodule : add_instruction_execute_tb_top
